// File: core/twb_core.sv
// two-wire bus error recovery, repeated start and multi-master arbitration core
`timescale 1ns/10ps
`include "twb_map.svh"
module twb_core (
    // clocks, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       link_clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // software control writes
    input  wire logic       ctl_wr,
    input  wire logic       ctl_sta,
    input  wire logic       ctl_sto,
    input  wire logic       ctl_ea,
    input  wire logic       ctl_done_wr1,
    input  wire logic [7:0] tx_data,
    input  wire logic [6:0] own_addr,
    // software status
    output logic      [7:0] status_code,
    output logic            done_flag,
    output logic            sta_bit,
    output logic            sto_bit,
    output logic            ea_bit,
    // bus pins, open drain
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_n,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n
);
    ////////////////////////////////////////////////////////////////////////////////////////////////
    logic              done_q, done_d, sta_q, sta_d, sto_q, sto_d, ea_q, ea_d;
    logic        [7:0] status_q, status_d;
    twb_pkg::cmd_t     cmd_q, cmd_d;
    logic              go_tgl_q, go_tgl_d, ev_p_q, ev_s, ev_pulse, go;
    logic              ev_tgl_q;
    logic        [7:0] ev_code_q;

    twb_sync2 #(.W(1)) u_ev_sync (.clk(ref_clk), .resetn(resetn), .d(ev_tgl_q), .q(ev_s));

    assign ev_pulse = ev_s ^ ev_p_q;
    // a write of one to the done flag hands the command to the link side
    assign go       = ctl_wr & ctl_done_wr1;

    always_comb begin
        sta_d    = ctl_wr ? ctl_sta : sta_q;
        ea_d     = ctl_wr ? ctl_ea : ea_q;
        sto_d    = go ? 1'b0 : (ctl_wr ? ctl_sto : sto_q);
        cmd_d    = go ? '{ctl_sta, ctl_sto, ctl_ea, tx_data} : cmd_q;
        go_tgl_d = go ? ~go_tgl_q : go_tgl_q;
        // event wins over a clear landing in the same cycle
        done_d   = ev_pulse | (done_q & ~go);
        status_d = done_d ? (ev_pulse ? ev_code_q : status_q) : `ST_IDLE;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            done_q   <= `CTL_BIT_RST;
            sta_q    <= `CTL_BIT_RST;
            sto_q    <= `CTL_BIT_RST;
            ea_q     <= `CTL_BIT_RST;
            status_q <= `STATUS_RST;
            cmd_q    <= '0;
            go_tgl_q <= 1'b0;
            ev_p_q   <= 1'b0;
        end else if (ce) begin
            done_q   <= done_d;
            sta_q    <= sta_d;
            sto_q    <= sto_d;
            ea_q     <= ea_d;
            status_q <= status_d;
            cmd_q    <= cmd_d;
            go_tgl_q <= go_tgl_d;
            ev_p_q   <= ev_s;
        end
    end

    assign status_code = status_q;
    assign done_flag   = done_q;
    assign sta_bit     = sta_q;
    assign sto_bit     = sto_q;
    assign ea_bit      = ea_q;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // link side; cmd_q is only read after its toggle is seen, so it is stable by then
    twb_pkg::link_state_t ls_q, ls_d;
    logic scl_s, sda_s, go_s, ce_l, go_l;
    logic scl_p_q, scl_p_d, sda_p_q, sda_p_d, busy_q, busy_d;
    logic [3:0] bcnt_q, bcnt_d, bidx_q, bidx_d;
    logic [7:0] shr_q, shr_d, txb_q, txb_d, qcnt_q, qcnt_d, ev_code_d;
    logic [1:0] ph_q, ph_d;
    logic owner_q, owner_d, addr_q, addr_d, nack_q, nack_d, go_p_q, go_p_d;
    logic scl_drv_q, scl_drv_d, sda_drv_q, sda_drv_d, ev_tgl_d;
    logic start_c, stop_c, rise, fall, berr, tick, timed, lose, lose_addr;
    logic scl_n_s, sda_n_s;

    // sampled inverted so that reset leaves both lines at their idle high level, no false edge after reset
    twb_sync2 #(.W(2)) u_pin_sync (.clk(link_clk), .resetn(resetn), .d({~scl_i, ~sda_i}), .q({scl_n_s, sda_n_s}));
    assign scl_s     = ~scl_n_s;
    assign sda_s     = ~sda_n_s;
    twb_sync2 #(.W(2)) u_go_sync (.clk(link_clk), .resetn(resetn), .d({go_tgl_q, ce}), .q({go_s, ce_l}));

    assign go_l      = go_s ^ go_p_q;
    assign start_c   = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c    = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign rise      = scl_s & ~scl_p_q;
    assign fall      = ~scl_s & scl_p_q;
    // start or stop legal on a byte boundary or in the first clock high after it (repeated start, stop)
    assign berr      = (start_c | stop_c) & busy_q & (bcnt_q > 4'h1);
    assign timed     = ls_q inside {twb_pkg::L_START, twb_pkg::L_BIT, twb_pkg::L_STOP};
    assign tick      = qcnt_q == 8'(`SCL_QTR_CYC - 1);
    // released line read back low means another master drove a zero
    assign lose      = (ls_q == twb_pkg::L_BIT) & tick & (ph_q == 2'h2) & (bidx_q < 4'h8)
                       & ~sda_drv_q & ~sda_s;
    assign lose_addr = addr_q & (bidx_q < 4'h7);

    always_comb begin
        logic       fire;
        logic [7:0] code;
        fire      = 1'b0;
        code      = `ST_IDLE;
        ls_d      = ls_q;
        scl_p_d   = scl_s;
        sda_p_d   = sda_s;
        busy_d    = start_c ? 1'b1 : (stop_c ? 1'b0 : busy_q);
        bcnt_d    = bcnt_q;
        shr_d     = rise ? {shr_q[6:0], sda_s} : shr_q;
        if (start_c) begin
            bcnt_d = 4'h0;
        end else if (rise) begin
            bcnt_d = bcnt_q + 4'h1;
        end else if (fall && bcnt_q == 4'h9) begin
            bcnt_d = 4'h0;
        end
        qcnt_d    = (!timed || tick) ? 8'h00 : qcnt_q + 8'h01;
        ph_d      = !timed ? 2'h0 : (tick ? ph_q + 2'h1 : ph_q);
        bidx_d    = bidx_q;
        txb_d     = txb_q;
        owner_d   = owner_q;
        addr_d    = addr_q;
        nack_d    = nack_q;
        go_p_d    = go_p_q;
        scl_drv_d = scl_drv_q;
        sda_drv_d = sda_drv_q;
        if (berr) begin
            // only internal state moves; lines let go, no stop driven
            ls_d      = twb_pkg::L_BERR;
            scl_drv_d = 1'b0;
            sda_drv_d = 1'b0;
            owner_d   = 1'b0;
            fire      = 1'b1;
            code      = `ST_BUS_ERR;
        end else begin
            unique case (ls_q)
                twb_pkg::L_IDLE: begin
                    // not-addressed slave; with no news it simply waits
                    if (go_l) begin
                        go_p_d = go_s;
                        txb_d  = cmd_q.data;
                        addr_d = 1'b1;
                        if (cmd_q.start_request_bit) begin
                            ls_d = twb_pkg::L_WAIT;
                        end
                    end
                end
                twb_pkg::L_WAIT: begin
                    if (!busy_q) begin
                        ls_d    = twb_pkg::L_START;
                        owner_d = 1'b1;
                    end
                end
                twb_pkg::L_HOLD: begin
                    // clock held low so no other master can take the bus
                    if (go_l) begin
                        go_p_d = go_s;
                        txb_d  = cmd_q.data;
                        bidx_d = 4'h0;
                        addr_d = cmd_q.start_request_bit;
                        if (cmd_q.sto) begin
                            ls_d = twb_pkg::L_STOP;
                        end else if (cmd_q.start_request_bit) begin
                            ls_d = twb_pkg::L_START;
                        end else begin
                            ls_d = twb_pkg::L_BIT;
                        end
                    end
                end
                twb_pkg::L_START: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h0: sda_drv_d = 1'b0;
                            2'h1: scl_drv_d = 1'b0;
                            2'h2: sda_drv_d = 1'b1;
                            2'h3: begin
                                scl_drv_d = 1'b1;
                                bidx_d    = 4'h0;
                                ls_d      = twb_pkg::L_BIT;
                            end
                        endcase
                    end
                end
                twb_pkg::L_BIT: begin
                    if (lose) begin
                        scl_drv_d = 1'b0;
                        sda_drv_d = 1'b0;
                        owner_d   = 1'b0;
                        if (lose_addr) begin
                            ls_d = twb_pkg::L_SLV;
                        end else begin
                            ls_d = twb_pkg::L_IDLE;
                            fire = 1'b1;
                            code = `ST_ARB_LOST;
                        end
                    end else if (tick) begin
                        unique case (ph_q)
                            2'h0: sda_drv_d = (bidx_q < 4'h8) ? ~txb_q[7] : 1'b0;
                            2'h1: scl_drv_d = 1'b0;
                            2'h2: nack_d = (bidx_q == 4'h8) ? sda_s : nack_q;
                            2'h3: begin
                                scl_drv_d = 1'b1;
                                txb_d     = {txb_q[6:0], 1'b0};
                                bidx_d    = bidx_q + 4'h1;
                                if (bidx_q == 4'h8) begin
                                    ls_d = twb_pkg::L_HOLD;
                                    fire = 1'b1;
                                    code = nack_q ? `ST_BYTE_NACK : `ST_BYTE_ACK;
                                end
                            end
                        endcase
                    end
                end
                twb_pkg::L_STOP: begin
                    if (tick) begin
                        unique case (ph_q)
                            2'h0: sda_drv_d = 1'b1;
                            2'h1: scl_drv_d = 1'b0;
                            2'h2: sda_drv_d = 1'b0;
                            2'h3: begin
                                owner_d = 1'b0;
                                ls_d    = twb_pkg::L_IDLE;
                            end
                        endcase
                    end
                end
                twb_pkg::L_SLV: begin
                    // listen to the winner's address; acknowledge on a hit
                    if (fall && bcnt_q == 4'h8) begin
                        fire = 1'b1;
                        if (shr_q[7:1] == own_addr) begin
                            sda_drv_d = cmd_q.ea;
                            code      = shr_q[0] ? `ST_ARB_OWN_R : `ST_ARB_OWN_W;
                        end else begin
                            ls_d = twb_pkg::L_IDLE;
                            code = `ST_ARB_NOT_ME;
                        end
                    end else if (fall && bcnt_q == 4'h9) begin
                        sda_drv_d = 1'b0;
                        ls_d      = twb_pkg::L_IDLE;
                    end
                end
                twb_pkg::L_BERR: begin
                    if (go_l) begin
                        go_p_d = go_s;
                        if (cmd_q.sto) begin
                            ls_d = twb_pkg::L_IDLE;
                        end
                    end
                end
                default: begin
                    ls_d      = twb_pkg::L_IDLE;
                    scl_drv_d = 1'b0;
                    sda_drv_d = 1'b0;
                    owner_d   = 1'b0;
                end
            endcase
        end
        ev_tgl_d  = fire ? ~ev_tgl_q : ev_tgl_q;
        ev_code_d = fire ? code : ev_code_q;
    end

    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            ls_q      <= twb_pkg::L_IDLE;
            scl_p_q   <= 1'b1;
            sda_p_q   <= 1'b1;
            busy_q    <= 1'b0;
            bcnt_q    <= 4'h0;
            shr_q     <= 8'h00;
            qcnt_q    <= 8'h00;
            ph_q      <= 2'h0;
            bidx_q    <= 4'h0;
            txb_q     <= 8'h00;
            owner_q   <= 1'b0;
            addr_q    <= 1'b0;
            nack_q    <= 1'b0;
            go_p_q    <= 1'b0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            ev_tgl_q  <= 1'b0;
            ev_code_q <= `STATUS_RST;
        end else if (ce_l) begin
            ls_q      <= ls_d;
            scl_p_q   <= scl_p_d;
            sda_p_q   <= sda_p_d;
            busy_q    <= busy_d;
            bcnt_q    <= bcnt_d;
            shr_q     <= shr_d;
            qcnt_q    <= qcnt_d;
            ph_q      <= ph_d;
            bidx_q    <= bidx_d;
            txb_q     <= txb_d;
            owner_q   <= owner_d;
            addr_q    <= addr_d;
            nack_q    <= nack_d;
            go_p_q    <= go_p_d;
            scl_drv_q <= scl_drv_d;
            sda_drv_q <= sda_drv_d;
            ev_tgl_q  <= ev_tgl_d;
            ev_code_q <= ev_code_d;
        end
    end

    // open drain: only ever pull low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_n = ~scl_drv_q;
    assign sda_oe_n = ~sda_drv_q;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    property p_idle_code;
        @(posedge ref_clk) disable iff (!resetn) !done_q |-> status_q == `ST_IDLE;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("status not idle while done clear");
    property p_berr_code;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && berr |=> ls_q == twb_pkg::L_BERR && ev_code_q == `ST_BUS_ERR && ev_tgl_q != $past(ev_tgl_q);
    endproperty
    a_berr_code: assert property (p_berr_code) else $error("bus error not reported");
    property p_done_on_ev;
        @(posedge ref_clk) disable iff (!resetn) ce && ev_pulse |=> done_q && status_q == $past(ev_code_q);
    endproperty
    a_done_on_ev: assert property (p_done_on_ev) else $error("event did not set done");
    property p_sto_clr;
        @(posedge ref_clk) disable iff (!resetn)
            ce && go |=> !sto_q && sta_q == $past(ctl_sta) && done_q == $past(ev_pulse);
    endproperty
    a_sto_clr: assert property (p_sto_clr) else $error("stop request not self-cleared");
    property p_berr_exit;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && !berr && ls_q == twb_pkg::L_BERR && go_l && cmd_q.sto |=> ls_q == twb_pkg::L_IDLE && !owner_q;
    endproperty
    a_berr_exit: assert property (p_berr_exit) else $error("no recovery to slave mode");
    property p_berr_release;
        @(posedge link_clk) disable iff (!resetn) ls_q == twb_pkg::L_BERR |-> !scl_drv_q && !sda_drv_q;
    endproperty
    a_berr_release: assert property (p_berr_release) else $error("line driven during bus error");
    property p_hold_bus;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && !berr && ls_q == twb_pkg::L_HOLD && go_l && cmd_q.start_request_bit && !cmd_q.sto
            |=> ls_q == twb_pkg::L_START && owner_q && scl_drv_q;
    endproperty
    a_hold_bus: assert property (p_hold_bus) else $error("bus given up at repeated start");
    property p_no_false_loss;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && !berr && ls_q == twb_pkg::L_BIT && tick && ph_q == 2'h2 && sda_s == !sda_drv_q |=> owner_q;
    endproperty
    a_no_false_loss: assert property (p_no_false_loss) else $error("loss on matching bit");
    property p_arb_lose;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && !berr && lose |=> !owner_q && !sda_drv_q && !scl_drv_q;
    endproperty
    a_arb_lose: assert property (p_arb_lose) else $error("arbitration loss missed");
    property p_lose_data;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && !berr && lose && !lose_addr |=> ls_q == twb_pkg::L_IDLE && ev_code_q == `ST_ARB_LOST;
    endproperty
    a_lose_data: assert property (p_lose_data) else $error("data loss not reported");
    property p_lose_addr;
        @(posedge link_clk) disable iff (!resetn) ce_l && !berr && lose && lose_addr |=> ls_q == twb_pkg::L_SLV;
    endproperty
    a_lose_addr: assert property (p_lose_addr) else $error("address loss not slave");
    property p_retry;
        @(posedge link_clk) disable iff (!resetn)
            ce_l && !berr && ls_q == twb_pkg::L_IDLE && go_l && cmd_q.start_request_bit |=> ls_q == twb_pkg::L_WAIT;
    endproperty
    a_retry: assert property (p_retry) else $error("restart request not waiting");
    c_berr: cover property (@(posedge link_clk) disable iff (!resetn) ls_q == twb_pkg::L_BERR);
    c_slv: cover property (@(posedge link_clk) disable iff (!resetn) ls_q == twb_pkg::L_SLV);
    c_rstart: cover property (@(posedge link_clk) disable iff (!resetn)
        ls_q == twb_pkg::L_HOLD ##1 ls_q == twb_pkg::L_START);
endmodule

// File: core/twb_map.svh
// status codes, reset values and timing counts of the two-wire error and arbitration block
`ifndef TWB_MAP_SVH
`define TWB_MAP_SVH
`define ST_IDLE       8'hF8
`define ST_BUS_ERR    8'h00
`define ST_BYTE_ACK   8'hE8
`define ST_BYTE_NACK  8'hF0
`define ST_ARB_LOST   8'hD0
`define ST_ARB_OWN_W  8'hD8
`define ST_ARB_OWN_R  8'hB0
`define ST_ARB_NOT_ME 8'hE0
`define STATUS_RST    `ST_IDLE
`define CTL_BIT_RST   1'b0
`define SCL_QTR_NS    2500
`define LINK_CLK_NS   12
`define SCL_QTR_CYC   ((`SCL_QTR_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)
`endif

// File: core/twb_pkg.sv
// types shared by the two-wire error and arbitration block
package twb_pkg;
    typedef enum logic [7:0] {
        L_IDLE  = 8'h01,
        L_WAIT  = 8'h02,
        L_START = 8'h04,
        L_BIT   = 8'h08,
        L_HOLD  = 8'h10,
        L_STOP  = 8'h20,
        L_SLV   = 8'h40,
        L_BERR  = 8'h80
    } link_state_t;
    typedef struct packed {
        logic       start_request_bit;
        logic       sto;
        logic       ea;
        logic [7:0] data;
    } cmd_t;
endpackage

// File: core/twb_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module twb_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// File: verif/twb_bus_partner.sv
// behavioural second master and slave on the shared two-wire bus
`timescale 1ns/10ps
module twb_bus_partner (
    // link clock
    input  wire logic link_clk,
    // resolved bus levels
    input  wire logic scl,
    input  wire logic sda,
    // pulls, high drives the line low
    output logic      scl_pull,
    output logic      sda_pull
);
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_start();
        forever begin
            @(negedge sda);
            if (scl === 1'b1) break;
        end
    endtask
    // clocks with a shorter low and longer high, so the device leads while it masters
    task automatic compete(input logic [7:0] pb, input logic ack);
        int i;
        int k;
        wait_start();
        for (i = 0; i < 9; i++) begin
            wait (scl === 1'b0);
            scl_pull = 1'b1;
            repeat (20) @(posedge link_clk);
            sda_pull = (i < 8) ? ~pb[7-i] : ack;
            repeat (380) @(posedge link_clk);
            scl_pull = 1'b0;
            wait (scl === 1'b1);
            for (k = 0; k < 430 && scl === 1'b1; k++) @(posedge link_clk);
            if (scl === 1'b1) scl_pull = 1'b1;
        end
        // stop only shows if nobody else holds the clock low
        repeat (20) @(posedge link_clk);
        sda_pull = 1'b1;
        repeat (380) @(posedge link_clk);
        scl_pull = 1'b0;
        repeat (200) @(posedge link_clk);
        sda_pull = 1'b0;
    endtask
    // start condition after the sample point of address bit 1
    task automatic inject_error();
        wait_start();
        repeat (2) @(posedge scl);
        repeat (300) @(posedge link_clk);
        sda_pull = 1'b1;
        repeat (300) @(posedge link_clk);
        sda_pull = 1'b0;
    endtask
endmodule

// File: verif/two_wire_bus_error_arbitration_bench.sv
// self-checking bench of the two-wire error and arbitration core
`timescale 1ns/10ps
module two_wire_bus_error_arbitration_bench;
    logic       ref_clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       ce = 1'b1;
    logic       ctl_wr = 1'b0;
    logic       ctl_sta = 1'b0;
    logic       ctl_sto = 1'b0;
    logic       ctl_ea = 1'b0;
    logic       ctl_done_wr1 = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [6:0] own_addr = 7'h11;
    logic [7:0] status_code;
    logic       done_flag, sta_bit, sto_bit, ea_bit;
    logic       scl_o, scl_oe_n, sda_o, sda_oe_n, scl_pull, sda_pull;
    wire        scl = (scl_oe_n | scl_o) & ~scl_pull;
    wire        sda = (sda_oe_n | sda_o) & ~sda_pull;
    int         num_errors = 0;
    int         n_checks = 0;
    always #5 ref_clk = ~ref_clk;
    initial begin
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    twb_core i_twb_core (.ref_clk(ref_clk), .link_clk(link_clk), .resetn(resetn), .ce(ce),
        .ctl_wr(ctl_wr), .ctl_sta(ctl_sta), .ctl_sto(ctl_sto), .ctl_ea(ctl_ea), .ctl_done_wr1(ctl_done_wr1),
        .tx_data(tx_data), .own_addr(own_addr), .status_code(status_code), .done_flag(done_flag),
        .sta_bit(sta_bit), .sto_bit(sto_bit), .ea_bit(ea_bit), .scl_i(scl), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    twb_bus_partner i_twb_bus_partner (.link_clk(link_clk), .scl(scl), .sda(sda), .scl_pull(scl_pull),
        .sda_pull(sda_pull));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic go(input logic start_request_bit, input logic sto, input logic [7:0] data);
        @(negedge ref_clk);
        {ctl_wr, ctl_done_wr1, ctl_sta, ctl_sto, ctl_ea, tx_data} = {2'b11, start_request_bit, sto, 1'b1, data};
        @(negedge ref_clk);
        {ctl_wr, ctl_done_wr1} = 2'b00;
    endtask
    // a byte plus start takes about 10000 cycles
    task automatic wait_done();
        int k;
        for (k = 0; k < 15000 && done_flag !== 1'b1; k++) @(negedge ref_clk);
        check("done in time", done_flag, 1'b1);
    endtask
    task automatic t_error();
        int k;
        fork
            i_twb_bus_partner.inject_error();
            begin go(1'b1, 1'b0, 8'hC0); wait_done(); end
        join
        check("error done", done_flag, 1'b1);
        check("error status", status_code, 8'h00);
        check("error lines", {scl_oe_n, sda_oe_n}, 8'h03);
        go(1'b0, 1'b1, 8'h00);
        check("recover done", done_flag, 1'b0);
        check("recover status", status_code, 8'hF8);
        check("recover bits", {sta_bit, sto_bit, ea_bit}, 8'h01);
        for (k = 0; k < 1500; k++) begin
            @(negedge ref_clk);
            if ({scl_oe_n, sda_oe_n, done_flag} !== 3'b110) break;
        end
        check("quiet after recovery", {scl_oe_n, sda_oe_n, done_flag}, 8'h06);
        $display("test bus error done");
    endtask
    task automatic t_restart();
        own_addr = 7'h11;
        fork
            i_twb_bus_partner.compete(8'hA0, 1'b1);
            begin go(1'b1, 1'b0, 8'hA0); wait_done(); end
        join
        check("same traffic status", status_code, 8'hE8);
        check("clock held", scl_oe_n, 1'b0);
        fork
            i_twb_bus_partner.compete(8'hA1, 1'b1);
            begin go(1'b1, 1'b0, 8'hA1); wait_done(); end
        join
        check("restart status", status_code, 8'hE8);
        go(1'b0, 1'b0, 8'h5A);
        wait_done();
        check("data byte status", status_code, 8'hF0);
        check("data clock held", scl_oe_n, 1'b0);
        go(1'b0, 1'b1, 8'h00);
        repeat (1500) @(negedge ref_clk);
        check("after stop lines", {scl_oe_n, sda_oe_n}, 8'h03);
        $display("test repeated start done");
    endtask
    task automatic t_arb();
        logic [7:0] dev_b [4] = '{8'hA1, 8'hA0, 8'hA0, 8'hA0};
        logic [7:0] par_b [4] = '{8'hA0, 8'h44, 8'h45, 8'h46};
        logic [7:0] exp_s [4] = '{8'hD0, 8'hD8, 8'hB0, 8'hE0};
        int i;
        for (i = 0; i < 4; i++) begin
            own_addr = (i == 0) ? 7'h11 : 7'h22;
            fork
                i_twb_bus_partner.compete(par_b[i], 1'b0);
                begin go(1'b1, 1'b0, dev_b[i]); wait_done(); end
            join
            check("lost status", status_code, exp_s[i]);
            go(1'b0, 1'b0, 8'h00);
            repeat (200) @(negedge ref_clk);
            check("slave done", done_flag, 1'b0);
            check("slave idle", status_code, 8'hF8);
            check("slave lines", {scl_oe_n, sda_oe_n}, 8'h03);
        end
        $display("test arbitration done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        repeat (10) @(negedge ref_clk);
        check("reset status", status_code, 8'hF8);
        check("reset flags", {done_flag, sta_bit, sto_bit, ea_bit, scl_oe_n, sda_oe_n}, 8'h03);
        // a command written while the enable is low must leave the done, start and ea bits and both lines untouched
        ce = 1'b0;
        go(1'b1, 1'b0, 8'h00);
        repeat (10) @(negedge ref_clk);
        check("frozen flags", {done_flag, sta_bit, ea_bit, scl_oe_n, sda_oe_n}, 8'h03);
        ce = 1'b1;
        repeat (10) @(negedge ref_clk);
        t_error();
        t_restart();
        t_arb();
        end_of_test();
    end
endmodule
